/* File: hbfs_pkg.sv */
`default_nettype none
package hbfs_pkg;
    localparam int NUM_BRIDGES = 6;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // register offsets
    localparam logic [7:0] ADDR_GLOBAL_STATUS = 8'h00;
    localparam logic [7:0] ADDR_HS_OC = 8'h04;
    localparam logic [7:0] ADDR_LS_OC = 8'h08;
    localparam logic [7:0] ADDR_ACT_CTRL = 8'h0C;

    // global status register fields
    localparam int BIT_TPW = 1;
    localparam int BIT_TSD = 2;
    localparam int BIT_NOT_POWER_ON_RESET_INDICATOR = 3;
    localparam int BIT_SUPPLY_OVERVOLTAGE_FLAG = 4;
    localparam int BIT_SUPPLY_UNDERVOLTAGE_FLAG = 5;
    localparam int BIT_LE = 6;

    // bridge activation control fields
    localparam int ACT_HS_LSB = 0;
    localparam int ACT_LS_LSB = 8;

    // values after reset
    localparam logic [15:0] ACT_CTRL_RST = 16'h0000;
    localparam logic NOT_POWER_ON_RESET_INDICATOR_RST = 1'b0;

    // timing
    localparam int CLK_MHZ = 20;
    localparam int DEAD_TIME_NS = 500;
    localparam int DEAD_CYCLES_RAW = (DEAD_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int DEAD_CYCLES = (DEAD_CYCLES_RAW < 1) ? 1 : DEAD_CYCLES_RAW;
    localparam int DEAD_W = 8;

    typedef enum logic [1:0] {
        BR_OFF,
        BR_HS_ON,
        BR_LS_ON,
        BR_DEAD
    } hbfs_bridge_state_type;
endpackage
`default_nettype wire

/* File: hbfs_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module hbfs_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk, // clock
    input wire logic arst_n, // async reset, active low
    input wire logic [WIDTH-1:0] async_in, // asynchronous levels
    output logic [WIDTH-1:0] sync_out // synchronised levels
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } hbfs_sync_state_type;

    hbfs_sync_state_type s_q;
    hbfs_sync_state_type s_d;

    // first stage feeds only the second stage
    always_comb
    begin
        s_d.meta = async_in;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.stable;
endmodule
`default_nettype wire

/* File: hbfs_supervisor.sv */
// Functional notes
// R1 - overcurrent on active switch: switch off, enable bit kept, load and switch flags set
// R2 - high and low side of one bridge are never on together
// R3 - dead time inserted between off and on, both directions
// R4 - any sensor at warning threshold sets thermal prewarning flag
// R5 - prewarning flag latched until host clears it; outputs stay active
// R6 - shutdown threshold latches all outputs off and sets shutdown flag until cleared
// R7 - enable bits kept during thermal events; cleared flag re-reads 1 if condition persists
// R8 - host clears shutdown flag to reactivate or recheck outputs
// R9 - supply undervoltage switches outputs off, keeps registers, latches flag
// R10 - outputs return automatically when supply recovers, flag untouched
// R11 - host clears undervoltage flag and rereads to check disruption
// R12 - supply overvoltage switches outputs off and latches flag
// R13 - outputs return automatically when overvoltage ends, flag stays latched
// R14 - host clears overvoltage flag to check whether overvoltage persists
// R15 - logic held in reset below power-off threshold; no bus response
// R16 - reset initialises all state and turns every output stage off
// R17 - reset released only once logic supply above power-on threshold
// R18 - after reset power-on indicator reads 0 once enable is high
// R19 - overcurrent switch stays off while its flag set; host clears to retry
// R20 - comparator indications synchronised before setting flags or gating outputs
`timescale 1ns/100ps
`default_nettype none
module hbfs_supervisor
    import hbfs_pkg::*;
#(
    parameter int NB = hbfs_pkg::NUM_BRIDGES
) (
    input wire logic sys_clk, // 20 MHz clock
    input wire logic arst_n, // logic-supply reset, active low
    input wire logic [hbfs_pkg::ADDR_W-1:0] reg_addr, // register byte address
    input wire logic [hbfs_pkg::DATA_W-1:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [hbfs_pkg::DATA_W-1:0] reg_rdata, // read data, cycle after strobe
    input wire logic [NB-1:0] oc_hs_in, // high-side overcurrent comparators
    input wire logic [NB-1:0] oc_ls_in, // low-side overcurrent comparators
    input wire logic temp_warn_in, // any sensor above warning threshold
    input wire logic temp_sd_in, // any sensor above shutdown threshold
    input wire logic supply_undervoltage_flag_in, // supply below undervoltage threshold
    input wire logic supply_overvoltage_flag_in, // supply above overvoltage threshold
    input wire logic en_in, // enable pin, normal mode when high
    output logic [NB-1:0] hs_on, // high-side gate command
    output logic [NB-1:0] ls_on, // low-side gate command
    output logic global_error // or of all error bits and power-on event
);
    localparam int NSYNC = 2 * NB + 5;

    typedef struct packed {
        hbfs_bridge_state_type [NB-1:0] br_st;
        logic [NB-1:0][DEAD_W-1:0] dead_cnt;
        logic [NB-1:0] hs_en;
        logic [NB-1:0] ls_en;
        logic [NB-1:0] hs_oc;
        logic [NB-1:0] ls_oc;
        logic le;
        logic thermal_prewarning_flag;
        logic thermal_shutdown_flag;
        logic supply_undervoltage_flag;
        logic supply_overvoltage_flag;
        logic not_power_on_reset_indicator;
        logic [DATA_W-1:0] rdata;
    } hbfs_state_type;

    hbfs_state_type s_q;
    hbfs_state_type s_d;

    logic [NSYNC-1:0] sync_v;
    logic [NB-1:0] oc_hs_s;
    logic [NB-1:0] oc_ls_s;
    logic warn_s;
    logic sd_s;
    logic uv_s;
    logic ov_s;
    logic en_s;

    // comparator levels come from analog domain
    hbfs_sync #(
        .WIDTH(NSYNC)
    ) u_sync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .async_in({oc_hs_in, oc_ls_in, temp_warn_in, temp_sd_in, supply_undervoltage_flag_in, supply_overvoltage_flag_in, en_in}),
        .sync_out(sync_v)
    ); // R20

    assign oc_hs_s = sync_v[NSYNC-1 -: NB];
    assign oc_ls_s = sync_v[NSYNC-NB-1 -: NB];
    assign warn_s = sync_v[4];
    assign sd_s = sync_v[3];
    assign uv_s = sync_v[2];
    assign ov_s = sync_v[1];
    assign en_s = sync_v[0];

    logic wr_ok;
    logic rd_ok;
    logic wr_glob;
    logic [NB-1:0] hs_set;
    logic [NB-1:0] ls_set;
    logic [NB-1:0] hs_clr;
    logic [NB-1:0] ls_clr;
    logic shut_all;
    logic hs_req;
    logic ls_req;
    logic [DATA_W-1:0] glob_v;
    logic [DATA_W-1:0] rd_v;

    always_comb
    begin
        s_d = s_q;
        // bus is dead while the enable pin is low
        wr_ok = reg_wr & en_s;
        rd_ok = reg_rd & en_s;
        wr_glob = wr_ok && (reg_addr == ADDR_GLOBAL_STATUS);
        hs_clr = (wr_ok && (reg_addr == ADDR_HS_OC)) ? reg_wdata[NB-1:0] : '0;
        ls_clr = (wr_ok && (reg_addr == ADDR_LS_OC)) ? reg_wdata[NB-1:0] : '0;

        // enable bits only change by software, never by faults
        if (wr_ok && (reg_addr == ADDR_ACT_CTRL))
        begin
            s_d.hs_en = reg_wdata[ACT_HS_LSB +: NB];
            s_d.ls_en = reg_wdata[ACT_LS_LSB +: NB];
        end // R7

        // overcurrent only counts on a switch that is driven
        hs_set = oc_hs_s & hs_on;
        ls_set = oc_ls_s & ls_on;
        s_d.hs_oc = (s_q.hs_oc & ~hs_clr) | hs_set; // R1
        s_d.ls_oc = (s_q.ls_oc & ~ls_clr) | ls_set; // R1
        s_d.le = (s_q.le & ~(wr_glob & reg_wdata[BIT_LE])) | (|{hs_set, ls_set}); // R1

        // set wins over clear: flag re-reads 1 while condition persists
        s_d.thermal_prewarning_flag = (s_q.thermal_prewarning_flag & ~(wr_glob & reg_wdata[BIT_TPW])) | warn_s; // R4 R5 R7
        s_d.thermal_shutdown_flag = (s_q.thermal_shutdown_flag & ~(wr_glob & reg_wdata[BIT_TSD])) | sd_s; // R6 R7
        s_d.supply_undervoltage_flag = (s_q.supply_undervoltage_flag & ~(wr_glob & reg_wdata[BIT_SUPPLY_UNDERVOLTAGE_FLAG])) | uv_s; // R9
        s_d.supply_overvoltage_flag = (s_q.supply_overvoltage_flag & ~(wr_glob & reg_wdata[BIT_SUPPLY_OVERVOLTAGE_FLAG])) | ov_s; // R12

        // host acknowledges the power-on event by writing 1
        if (wr_glob && reg_wdata[BIT_NOT_POWER_ON_RESET_INDICATOR])
        begin
            s_d.not_power_on_reset_indicator = 1'b1;
        end // R18

        // supply faults gate on the live level, so outputs return by themselves
        shut_all = s_q.thermal_shutdown_flag | sd_s | uv_s | ov_s; // R6 R9 R10 R12 R13
        hs_req = 1'b0;
        ls_req = 1'b0;

        for (int i = 0; i < NB; i++)
        begin
            // both sides requested is treated as off, never as cross conduction
            hs_req = s_q.hs_en[i] & ~s_q.ls_en[i] & ~s_q.hs_oc[i] & ~hs_set[i] & ~shut_all; // R2 R19
            ls_req = s_q.ls_en[i] & ~s_q.hs_en[i] & ~s_q.ls_oc[i] & ~ls_set[i] & ~shut_all; // R2 R19
            case (s_q.br_st[i])
                BR_OFF:
                begin
                    if (hs_req)
                    begin
                        s_d.br_st[i] = BR_HS_ON;
                    end
                    else if (ls_req)
                    begin
                        s_d.br_st[i] = BR_LS_ON;
                    end
                end
                BR_HS_ON:
                begin
                    if (!hs_req)
                    begin
                        s_d.br_st[i] = BR_DEAD;
                        s_d.dead_cnt[i] = DEAD_W'(DEAD_CYCLES - 1);
                    end // R3
                end
                BR_LS_ON:
                begin
                    if (!ls_req)
                    begin
                        s_d.br_st[i] = BR_DEAD;
                        s_d.dead_cnt[i] = DEAD_W'(DEAD_CYCLES - 1);
                    end // R3
                end
                BR_DEAD:
                begin
                    // both sides off for the full dead time before any turn-on
                    if (s_q.dead_cnt[i] == '0)
                    begin
                        s_d.br_st[i] = BR_OFF;
                    end
                    else
                    begin
                        s_d.dead_cnt[i] = s_q.dead_cnt[i] - 1'b1;
                    end // R3
                end
                default:
                begin
                    s_d.br_st[i] = BR_OFF;
                end
            endcase
        end

        glob_v = '0;
        glob_v[BIT_TPW] = s_q.thermal_prewarning_flag;
        glob_v[BIT_TSD] = s_q.thermal_shutdown_flag;
        glob_v[BIT_NOT_POWER_ON_RESET_INDICATOR] = s_q.not_power_on_reset_indicator; // R18
        glob_v[BIT_SUPPLY_OVERVOLTAGE_FLAG] = s_q.supply_overvoltage_flag;
        glob_v[BIT_SUPPLY_UNDERVOLTAGE_FLAG] = s_q.supply_undervoltage_flag;
        glob_v[BIT_LE] = s_q.le;

        case (reg_addr)
            ADDR_GLOBAL_STATUS: rd_v = glob_v;
            ADDR_HS_OC: rd_v = DATA_W'(s_q.hs_oc);
            ADDR_LS_OC: rd_v = DATA_W'(s_q.ls_oc);
            ADDR_ACT_CTRL:
            begin
                rd_v = '0;
                rd_v[ACT_HS_LSB +: NB] = s_q.hs_en;
                rd_v[ACT_LS_LSB +: NB] = s_q.ls_en;
            end
            default: rd_v = '0;
        endcase
        // read data stand one cycle only
        s_d.rdata = rd_ok ? rd_v : '0; // R15
    end

    // reset clears every flop, gates are off and not_power_on_reset_indicator reads 0
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_q <= '0;
            s_q.hs_en <= ACT_CTRL_RST[ACT_HS_LSB +: NB];
            s_q.ls_en <= ACT_CTRL_RST[ACT_LS_LSB +: NB];
            s_q.not_power_on_reset_indicator <= NOT_POWER_ON_RESET_INDICATOR_RST;
        end // R15 R16 R17
        else
        begin
            s_q <= s_d;
        end
    end

    always_comb
    begin
        for (int i = 0; i < NB; i++)
        begin
            hs_on[i] = (s_q.br_st[i] == BR_HS_ON); // R2
            ls_on[i] = (s_q.br_st[i] == BR_LS_ON); // R2
        end
    end

    assign reg_rdata = s_q.rdata;
    assign global_error = s_q.le | s_q.thermal_prewarning_flag | s_q.thermal_shutdown_flag | s_q.supply_undervoltage_flag | s_q.supply_overvoltage_flag | ~s_q.not_power_on_reset_indicator;
endmodule
`default_nettype wire

/* File: hbfs_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module hbfs_properties
    import hbfs_pkg::*;
#(
    parameter int NB = 6
) (
    input wire logic sys_clk, // clock
    input wire logic arst_n, // reset
    input wire logic [NB-1:0] oc_hs_in, // hs fault
    input wire logic temp_warn_in, // warning
    input wire logic temp_sd_in, // shutdown
    input wire logic supply_undervoltage_flag_in, // undervoltage
    input wire logic supply_overvoltage_flag_in, // overvoltage
    input wire logic [NB-1:0] hs_on, // hs gate
    input wire logic [NB-1:0] ls_on // ls gate
);
    // cycles since each side of bridge 0 was last on
    logic [7:0] hs_q;
    logic [7:0] ls_q;
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hs_q <= 8'hFF;
            ls_q <= 8'hFF;
        end
        else
        begin
            hs_q <= hs_on[0] ? 8'h00 : hs_q + {7'h00, hs_q != 8'hFF};
            ls_q <= ls_on[0] ? 8'h00 : ls_q + {7'h00, ls_q != 8'hFF};
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    a_no_cross: assert property ((hs_on & ls_on) == '0)
        else $error("cross conduction");
    a_dead_to_ls: assert property ($rose(ls_on[0]) |-> hs_q >= DEAD_CYCLES)
        else $error("ls dead time short");
    a_dead_to_hs: assert property ($rose(hs_on[0]) |-> ls_q >= DEAD_CYCLES)
        else $error("hs dead time short");
    a_oc_cuts_hs: assert property ($rose(oc_hs_in[0]) && hs_on[0] |-> ##[1:4] !hs_on[0])
        else $error("overcurrent switch kept on");
    a_tsd_all_off: assert property ($rose(temp_sd_in) |-> ##[1:4] (hs_on | ls_on) == '0)
        else $error("outputs on in shutdown");
    a_uv_all_off: assert property ($rose(supply_undervoltage_flag_in) |-> ##[1:4] (hs_on | ls_on) == '0)
        else $error("outputs on in undervoltage");
    a_warn_keeps_on: assert property ($rose(temp_warn_in) && hs_on[0] && !temp_sd_in && !supply_undervoltage_flag_in
        && !supply_overvoltage_flag_in && oc_hs_in == '0 |=> hs_on[0] [*4])
        else $error("warning dropped output");
    a_sync_lag: assert property ($rose(supply_undervoltage_flag_in) && hs_on[0] |=> hs_on[0])
        else $error("unsynchronised gating");
    c_ls_on: cover property ($rose(ls_on[0]));
    c_oc_hit: cover property ($rose(oc_hs_in[0]) && hs_on[0]);
    c_tsd: cover property ($rose(temp_sd_in));
endmodule
bind hbfs_supervisor hbfs_properties #(.NB(NB)) u_hbfs_properties (.sys_clk, .arst_n, .oc_hs_in,
    .temp_warn_in, .temp_sd_in, .supply_undervoltage_flag_in, .supply_overvoltage_flag_in, .hs_on, .ls_on);
`default_nettype wire

/* File: hbfs_host.sv */
`timescale 1ns/100ps
`default_nettype none
module hbfs_host (
    input wire logic sys_clk, // clock
    output logic [7:0] reg_addr = 8'h00, // address
    output logic [15:0] reg_wdata = 16'h0000, // write data
    output logic reg_wr = 1'b0, // write strobe
    output logic reg_rd = 1'b0, // read strobe
    input wire logic [15:0] reg_rdata // read data
);
    // flag clears are plain one-cycle writes
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import hbfs_pkg::*;
    localparam logic [7:0] GS = ADDR_GLOBAL_STATUS;
    localparam logic [7:0] AC = ADDR_ACT_CTRL;
    logic sys_clk = 0;
    logic arst_n = 0;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic reg_wr, reg_rd, global_error, temp_warn_in = 0, temp_sd_in = 0, supply_undervoltage_flag_in = 0, supply_overvoltage_flag_in = 0, en_in = 1;
    logic [5:0] oc_hs_in = 0, oc_ls_in = 0, hs_on, ls_on;
    int n_fail = 0, total_checks = 0, i;
    always #25 sys_clk = ~sys_clk;
    hbfs_host u_hbfs_host (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    hbfs_supervisor u_hbfs_supervisor (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .oc_hs_in, .oc_ls_in, .temp_warn_in, .temp_sd_in, .supply_undervoltage_flag_in, .supply_overvoltage_flag_in, .en_in, .hs_on, .ls_on, .global_error);
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic results;
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [15:0] e);
        u_hbfs_host.rd(a, d);
        chk(nm, e, d);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        u_hbfs_host.wr(a, v);
    endtask
    task automatic t_dead;
        wr(AC, 16'h0001);
        wt(4);
        for (int k = 0; k < 2; k++)
        begin
            wr(AC, k ? 16'h0001 : 16'h0100);
            for (i = 0; i < 40 && (k ? hs_on[0] : ls_on[0]) !== 1'b1; i++)
                @(posedge sys_clk);
            if (i == 40)
            begin
                n_fail++;
                $display("[ERR] dead wait exp %0d got %0d", 1, 0);
                results;
            end
            chk("dead", 16'h0001, 16'(i >= DEAD_CYCLES));
        end
        wr(AC, 16'h0101);
        wt(15);
        chk("both", 16'h0000, 16'(hs_on | ls_on));
        $display("t_dead done");
    endtask
    task automatic t_oc;
        for (int s = 0; s < 2; s++)
        begin
            wr(AC, s ? 16'h0100 : 16'h0001);
            wt(15);
            oc_hs_in <= s ? 6'h00 : 6'h01;
            oc_ls_in <= s ? 6'h01 : 6'h00;
            wt(5);
            oc_hs_in <= 6'h00;
            oc_ls_in <= 6'h00;
            wt(5);
            chk("oc off", 16'h0000, 16'(hs_on | ls_on));
            rchk("oc flag", s ? ADDR_LS_OC : ADDR_HS_OC, 16'h0001);
            rchk("oc le", GS, 16'h0048);
            rchk("oc act", AC, s ? 16'h0100 : 16'h0001);
            wr(s ? ADDR_LS_OC : ADDR_HS_OC, 16'h0001);
            wr(GS, 16'h0040);
            wt(5);
            chk("oc back", 16'h0001, 16'(hs_on | ls_on));
        end
        $display("t_oc done");
    endtask
    task automatic t_therm;
        wr(AC, 16'h0001);
        wt(15);
        temp_warn_in <= 1;
        wt(5);
        chk("warn on", 16'h0001, 16'(hs_on));
        wr(GS, 16'h0002);
        rchk("tpw held", GS, 16'h000A);
        temp_warn_in <= 0;
        wt(3);
        wr(GS, 16'h0002);
        rchk("tpw clr", GS, 16'h0008);
        temp_sd_in <= 1;
        wt(5);
        temp_sd_in <= 0;
        wt(15);
        chk("tsd off", 16'h0000, 16'(hs_on));
        rchk("tsd", GS, 16'h000C);
        rchk("tsd act", AC, 16'h0001);
        wr(GS, 16'h0004);
        wt(15);
        chk("tsd back", 16'h0001, 16'(hs_on));
        $display("t_therm done");
    endtask
    task automatic t_sup;
        for (int v = 0; v < 2; v++)
        begin
            supply_undervoltage_flag_in <= !v;
            supply_overvoltage_flag_in <= v;
            wt(5);
            chk("sup off", 16'h0000, 16'(hs_on));
            supply_undervoltage_flag_in <= 0;
            supply_overvoltage_flag_in <= 0;
            wt(15);
            chk("sup back", 16'h0001, 16'(hs_on));
            rchk("sup flag", GS, v ? 16'h0018 : 16'h0028);
            rchk("sup act", AC, 16'h0001);
            wr(GS, v ? 16'h0010 : 16'h0020);
            rchk("sup clr", GS, 16'h0008);
        end
        $display("t_sup done");
    endtask
    task automatic t_por;
        wt(3);
        chk("rst gates", 16'h0000, 16'({hs_on, ls_on}));
        arst_n <= 1;
        wt(3);
        chk("gerr", 16'h0001, 16'(global_error));
        rchk("not_power_on_reset_indicator", GS, 16'h0000);
        wr(GS, 16'h0008);
        wr(8'h10, 16'hFFFF);
        rchk("unmapped", 8'h10, 16'h0000);
        rchk("ack", GS, 16'h0008);
        chk("gerr ack", 16'h0000, 16'(global_error));
        $display("t_por done");
    endtask
    task automatic t_reset;
        en_in <= 0;
        wt(4);
        rchk("en low", GS, 16'h0000);
        arst_n <= 0;
        wt(2);
        chk("rst off", 16'h0000, 16'(hs_on | ls_on));
        en_in <= 1;
        arst_n <= 1;
        wt(3);
        chk("gerr por", 16'h0001, 16'(global_error));
        rchk("por again", GS, 16'h0000);
        $display("t_reset done");
    endtask
    initial
    begin
        t_por;
        t_dead;
        t_oc;
        t_therm;
        t_sup;
        t_reset;
        results;
    end
endmodule
`default_nettype wire
